// *** logic/t2ar_pkg.sv ***
// Constants, register map and state type of the auto-reload timer block.
// Operation
// RQ1: Count is a low and high byte; control bit 3 picks 16-bit or split mode.
// RQ2: Counting clock is system clock, system clock over 12, or external over 8.
// RQ3: Divided external oscillator tick is synchronised before it advances a byte.
// RQ4: 16-bit wrap from all ones loads the reload value and sets high flag.
// RQ5: 16-bit mode with timer interrupt enabled interrupts on every full overflow.
// RQ6: 16-bit mode with low enable also interrupts on each low byte wrap.
// RQ7: Split mode runs two 8-bit counters, each reloading from its reload byte.
// RQ8: Split mode gates only the high byte with run; low byte always counts.
// RQ9: Per byte select bit 1 picks system clock, else external select decides.
// RQ10: High flag sets on high byte wrap, low flag on low byte wrap.
// RQ11: Split mode interrupts on high wraps, and on either with low enable.
// RQ12: Hardware never clears the overflow flags; software writes zero to clear.
// RQ13: Low flag sets on every low byte wrap in either mode.
// RQ14: With low enable, the handler reads both flags to find the source.
// RQ15: Control resets to zero; bit 1 reads zero and is read-only.
// RQ16: Run bit high lets the timer (split: high byte) count; low holds it.
// RQ17: Each enabled byte steps by one per tick; reload replaces wrap same tick.
package t2ar_pkg;

  // ==========================================================================
  // Register indices; the byte address of each is four times its index.
  localparam logic [7:0] IDX_CONTROL = 8'hc8;
  localparam logic [7:0] IDX_RELOAD_LOW = 8'hca;
  localparam logic [7:0] IDX_RELOAD_HIGH = 8'hcb;
  localparam logic [7:0] IDX_COUNT_LOW = 8'hcc;
  localparam logic [7:0] IDX_COUNT_HIGH = 8'hcd;
  localparam logic [7:0] IDX_CLOCK_CONTROL = 8'hce;
  localparam logic [7:0] IDX_IRQ_STATUS = 8'hd0;
  localparam logic [7:0] IDX_IRQ_MASK = 8'hd1;

  // ==========================================================================
  // Control register fields.
  localparam int CTL_HIGH_FLAG = 7;
  localparam int CTL_LOW_FLAG = 6;
  localparam int CTL_LOW_IRQ_EN = 5;
  localparam int CTL_SPLIT = 3;
  localparam int CTL_RUN = 2;
  localparam int CTL_READ_ONLY = 1;
  localparam int CTL_EXT_SEL = 0;

  // Clock control fields, interrupt status and mask fields.
  localparam int CKC_LOW_SEL = 0;
  localparam int CKC_HIGH_SEL = 1;
  localparam int IRQ_HIGH = 0;
  localparam int IRQ_LOW = 1;

  // ==========================================================================
  // Reset values.
  localparam logic [7:0] RST_CONTROL = 8'h00;
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [1:0] RST_PAIR = 2'h0;

  // ==========================================================================
  // Clock divider end values and the byte wrap value.
  localparam logic [3:0] DIV_SYS_LAST = 4'hb;
  localparam logic [2:0] DIV_EXT_LAST = 3'h7;
  localparam logic [7:0] BYTE_ALL_ONES = 8'hff;

  typedef struct packed {
    logic [7:0] control;
    logic [1:0] clockSel;
    logic [7:0] reloadLow;
    logic [7:0] reloadHigh;
    logic [7:0] countLow;
    logic [7:0] countHigh;
    logic [1:0] irqStatus;
    logic [1:0] irqMask;
    logic [3:0] sysDiv;
    logic [2:0] extDiv;
    logic [1:0] extSync;
    logic extPrev;
    logic ack;
    logic [31:0] readData;
    logic irq;
  } t2ar_state_t;

endpackage : t2ar_pkg

// *** logic/t2ar_timer.sv ***
// Timer with auto-reload, 16-bit or split 8-bit, behind a Wishbone slave.
module t2ar_timer
  import t2ar_pkg::*;
#(
  parameter int ADR_W = 10
) (
  input wire logic ref_clk,
  input wire logic arst_n,
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [ADR_W-1:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] dat_i,
  output logic [31:0] dat_o,
  output logic ack_o,
  input wire logic extOscClk,
  output logic irq
);

  // ==========================================================================
  // Read multiplexer.
  function automatic logic [7:0] readByte(
    input t2ar_state_t s,
    input logic [7:0] idx
  );
    logic [7:0] v;
    v = 8'h00;
    case (idx)
      IDX_CONTROL: begin
        v = s.control;
        v[CTL_READ_ONLY] = 1'b0; // see RQ15
      end
      IDX_RELOAD_LOW: v = s.reloadLow;
      IDX_RELOAD_HIGH: v = s.reloadHigh;
      IDX_COUNT_LOW: v = s.countLow;
      IDX_COUNT_HIGH: v = s.countHigh;
      IDX_CLOCK_CONTROL: v = {6'h00, s.clockSel};
      IDX_IRQ_STATUS: v = {6'h00, s.irqStatus};
      IDX_IRQ_MASK: v = {6'h00, s.irqMask};
      default: v = 8'h00;
    endcase
    return v;
  endfunction

  t2ar_state_t state_reg;
  t2ar_state_t state_next;

  logic request;
  logic writeReq;
  logic readReq;
  logic [7:0] wordIdx;
  logic extEdge;
  logic extTick;
  logic sysTick;
  logic altTick;
  logic lowTick;
  logic highTick;
  logic lowWrap;
  logic highWrap;
  logic splitMode;
  logic runOn;
  logic [15:0] count16;
  logic [7:0] wrByte;

  always_comb begin
    state_next = state_reg;
    request = cyc_i && stb_i && !state_reg.ack;
    writeReq = request && we_i && sel_i[0];
    readReq = request && !we_i;
    wordIdx = adr_i[9:2];
    wrByte = dat_i[7:0];
    state_next.ack = request;

    // ========================================================================
    // Clock sources.
    // The pin is slower than ref_clk by design; two flops, then an edge.
    state_next.extSync = {state_reg.extSync[0], extOscClk}; // see RQ3
    state_next.extPrev = state_reg.extSync[1];
    extEdge = state_reg.extSync[1] && !state_reg.extPrev; // see RQ3
    extTick = 1'b0;
    if (extEdge) begin
      if (state_reg.extDiv == DIV_EXT_LAST) begin
        state_next.extDiv = 3'h0;
        extTick = 1'b1; // see RQ2
      end else begin
        state_next.extDiv = state_reg.extDiv + 3'h1;
      end
    end
    sysTick = 1'b0;
    if (state_reg.sysDiv == DIV_SYS_LAST) begin
      state_next.sysDiv = 4'h0;
      sysTick = 1'b1; // see RQ2
    end else begin
      state_next.sysDiv = state_reg.sysDiv + 4'h1;
    end
    altTick = state_reg.control[CTL_EXT_SEL] ? extTick : sysTick; // see RQ9
    lowTick = state_reg.clockSel[CKC_LOW_SEL] ? 1'b1 : altTick; // see RQ9
    highTick = state_reg.clockSel[CKC_HIGH_SEL] ? 1'b1 : altTick; // see RQ9

    // ========================================================================
    // Counting.
    splitMode = state_reg.control[CTL_SPLIT]; // see RQ1
    runOn = state_reg.control[CTL_RUN];
    count16 = {state_reg.countHigh, state_reg.countLow};
    lowWrap = 1'b0;
    highWrap = 1'b0;
    if (!splitMode) begin
      // The low byte's select bit clocks the whole 16-bit counter.
      if (runOn && lowTick) begin // see RQ16
        lowWrap = state_reg.countLow == BYTE_ALL_ONES; // see RQ13
        if (count16 == 16'hffff) begin
          highWrap = 1'b1; // see RQ4
          state_next.countHigh = state_reg.reloadHigh; // see RQ4
          state_next.countLow = state_reg.reloadLow; // see RQ17
        end else begin
          {state_next.countHigh, state_next.countLow} = count16 + 16'h1;
        end
      end
    end else begin
      if (lowTick) begin // see RQ8
        lowWrap = state_reg.countLow == BYTE_ALL_ONES; // see RQ10
        state_next.countLow = lowWrap ? state_reg.reloadLow
                                      : state_reg.countLow + 8'h01; // see RQ7
      end
      if (runOn && highTick) begin // see RQ16
        highWrap = state_reg.countHigh == BYTE_ALL_ONES; // see RQ10
        state_next.countHigh = highWrap ? state_reg.reloadHigh
                                        : state_reg.countHigh + 8'h01; // see RQ7
      end
    end

    // ========================================================================
    // Register writes; a software write to a count byte wins over a tick.
    if (writeReq) begin
      case (wordIdx)
        IDX_CONTROL: begin
          state_next.control = wrByte;
          state_next.control[CTL_READ_ONLY] = 1'b0; // see RQ15
        end
        IDX_RELOAD_LOW: state_next.reloadLow = wrByte;
        IDX_RELOAD_HIGH: state_next.reloadHigh = wrByte;
        IDX_COUNT_LOW: state_next.countLow = wrByte;
        IDX_COUNT_HIGH: state_next.countHigh = wrByte;
        IDX_CLOCK_CONTROL: state_next.clockSel = wrByte[1:0];
        IDX_IRQ_MASK: state_next.irqMask = wrByte[1:0];
        default: state_next.ack = request;
      endcase
    end
    // Hardware only ever sets the flags here; a control write also loads them, so clearing is a software write of zero.
    // A wrap in the same cycle as that write keeps the flag set.
    if (highWrap) begin
      state_next.control[CTL_HIGH_FLAG] = 1'b1; // see RQ12
    end
    if (lowWrap) begin
      state_next.control[CTL_LOW_FLAG] = 1'b1; // see RQ13
    end

    // ========================================================================
    // Interrupt status: cleared by its read, but a new event wins.
    if (readReq && wordIdx == IDX_IRQ_STATUS) begin
      state_next.irqStatus = RST_PAIR;
    end
    if (highWrap) begin
      state_next.irqStatus[IRQ_HIGH] = 1'b1; // see RQ5
    end
    if (lowWrap) begin
      state_next.irqStatus[IRQ_LOW] = 1'b1; // see RQ6
    end
    // Mask bit 0 is the timer interrupt enable; the low source also
    // needs the low-byte enable in control and its own mask bit.
    state_next.irq = state_next.irqMask[IRQ_HIGH]
      && (state_next.irqStatus[IRQ_HIGH]
          || (state_next.irqStatus[IRQ_LOW]
              && state_next.irqMask[IRQ_LOW]
              && state_next.control[CTL_LOW_IRQ_EN])); // see RQ11

    // ========================================================================
    // Read data; unmapped words read as zero and still acknowledge.
    state_next.readData = 32'h0000_0000;
    if (readReq) begin
      state_next.readData = {24'h00_0000, readByte(state_reg, wordIdx)};
    end
  end

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      state_reg.control <= RST_CONTROL; // see RQ15
      state_reg.clockSel <= RST_PAIR;
      state_reg.reloadLow <= RST_BYTE;
      state_reg.reloadHigh <= RST_BYTE;
      state_reg.countLow <= RST_BYTE;
      state_reg.countHigh <= RST_BYTE;
      state_reg.irqStatus <= RST_PAIR;
      state_reg.irqMask <= RST_PAIR;
      state_reg.sysDiv <= 4'h0;
      state_reg.extDiv <= 3'h0;
      state_reg.extSync <= 2'h0;
      state_reg.extPrev <= 1'b0;
      state_reg.ack <= 1'b0;
      state_reg.readData <= 32'h0000_0000;
      state_reg.irq <= 1'b0;
    end else begin
      state_reg <= state_next;
    end
  end

  assign dat_o = state_reg.readData;
  assign ack_o = state_reg.ack;
  assign irq = state_reg.irq;

endmodule // t2ar_timer

// *** testbench/t2ar_timer_props.sv ***
// Bus handshake, read data and interrupt checks for the auto-reload timer.
module t2ar_timer_props
  import t2ar_pkg::*;
#(
  parameter int ADR_W = 10
) (
  input wire logic ref_clk,
  input wire logic arst_n,
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [ADR_W-1:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] dat_i,
  input wire logic [31:0] dat_o,
  input wire logic ack_o,
  input wire logic extOscClk,
  input wire logic irq
);
  // ==========================================================================
  // Properties.
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!arst_n);
  logic take;
  assign take = cyc_i & stb_i & !ack_o;
  ack_answer_a: assert property (take |=> ack_o) else $error("no ack");
  ack_pulse_a: assert property (ack_o |=> !ack_o) else $error("long ack");
  ack_cause_a: assert property (ack_o |-> $past(take)) else $error("stray ack");
  dat_idle_a: assert property (!ack_o |-> dat_o == 32'h0) else $error("data idle");
  dat_upper_a: assert property (ack_o |-> dat_o[31:8] == 24'h0) else $error("upper data");
  ctl_bit_a: assert property (ack_o && $past(!we_i && adr_i[9:2] == IDX_CONTROL)
    |-> !dat_o[CTL_READ_ONLY]) else $error("read-only bit set");
  hole_read_a: assert property (ack_o && $past(!we_i && adr_i[9:2] == 8'h00)
    |-> dat_o == 32'h0) else $error("unmapped read");
  irq_fall_a: assert property ($fell(irq) |-> ack_o) else $error("irq dropped alone");
  cover property ($rose(irq));
  cover property (ack_o && we_i);
  cover property (ack_o && !we_i && dat_o[CTL_HIGH_FLAG]);
endmodule // t2ar_timer_props

bind t2ar_timer t2ar_timer_props #(.ADR_W(ADR_W)) u_t2ar_timer_props (
  .ref_clk(ref_clk), .arst_n(arst_n), .cyc_i(cyc_i), .stb_i(stb_i),
  .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o),
  .ack_o(ack_o), .extOscClk(extOscClk), .irq(irq));

// *** testbench/tb_top.sv ***
// Self-checking bench of the auto-reload timer.
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import t2ar_pkg::*;
  // ==========================================================================
  // Stimulus and design.
  logic ref_clk = 1'b0, arst_n = 1'b0, cyc_i = 1'b0, stb_i = 1'b0;
  logic we_i = 1'b0, extOscClk = 1'b0, ack_o, irq;
  logic [9:0] adr_i = 10'h000;
  logic [3:0] sel_i = 4'h1;
  logic [31:0] dat_i = 32'h0, dat_o;
  logic [7:0] rd;
  logic [2:0] extCnt = 3'h0;
  logic [7:0] regs [6] = '{IDX_CONTROL, IDX_RELOAD_LOW, IDX_RELOAD_HIGH,
    IDX_COUNT_LOW, IDX_COUNT_HIGH, 8'h00};
  int failures = 0, checked = 0, rl, lo;
  always #2.5 ref_clk = ~ref_clk;
  // Oscillator rises every sixth cycle so one divided tick spans 48 cycles.
  always @(posedge ref_clk) begin
    extCnt <= (extCnt == 3'h2) ? 3'h0 : extCnt + 3'h1;
    if (extCnt == 3'h2) extOscClk <= ~extOscClk;
  end
  t2ar_timer u_t2ar_timer (.ref_clk(ref_clk), .arst_n(arst_n), .cyc_i(cyc_i),
    .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i),
    .dat_o(dat_o), .ack_o(ack_o), .extOscClk(extOscClk), .irq(irq));
  // ==========================================================================
  // Tasks.
  task automatic print_verdict();
    if (failures == 0 && checked > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task automatic chk(string name, logic [31:0] exp, logic [31:0] got);
    checked++;
    if (got !== exp) begin
      failures++;
      $display("unexpected %s expected %h seen %h", name, exp, got);
    end
  endtask
  task automatic span(string name, int a, int b, logic [7:0] got);
    checked++;
    if ($isunknown(got) || got < a || got > b) begin
      failures++;
      $display("unexpected %s expected %0d..%0d seen %0d", name, a, b, got);
    end
  endtask
  task automatic wb(logic we, logic [7:0] idx, logic [7:0] wd);
    int n;
    n = 0;
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    we_i <= we;
    adr_i <= {idx, 2'b00};
    dat_i <= {24'h0, wd};
    do begin
      @(posedge ref_clk);
      n++;
    end while (ack_o !== 1'b1 && n < 20);
    rd = dat_o[7:0];
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
    if (ack_o !== 1'b1) begin
      chk("ack", 1, 0);
      print_verdict();
    end
    @(posedge ref_clk);
  endtask
  task automatic waitirq();
    int n;
    n = 0;
    while (irq !== 1'b1 && n < 300) begin
      @(posedge ref_clk);
      n++;
    end
    chk("irq", 1, irq);
    if (irq !== 1'b1) begin
      print_verdict();
    end
  endtask
  // ==========================================================================
  // Main sequence.
  initial begin
    void'($urandom(32'hf5ba64de));
    rl = $urandom_range(128, 16);
    repeat (2) @(posedge ref_clk);
    arst_n <= 1'b1;
    @(posedge ref_clk);
    foreach (regs[i]) begin
      wb(0, regs[i], 0);
      chk("reset value", 0, rd);
    end
    wb(1, IDX_CONTROL, 8'hf3);
    wb(0, IDX_CONTROL, 0);
    chk("control", 8'hf1, rd);
    wb(1, IDX_CONTROL, 0);
    wb(1, IDX_CLOCK_CONTROL, 8'h01);
    wb(1, IDX_RELOAD_HIGH, 8'h12);
    wb(1, IDX_RELOAD_LOW, rl[7:0]);
    wb(1, IDX_COUNT_HIGH, 8'hff);
    wb(1, IDX_COUNT_LOW, 8'hf0);
    wb(1, IDX_IRQ_MASK, 8'h01);
    wb(1, IDX_CONTROL, 8'h04);
    waitirq();
    wb(0, IDX_CONTROL, 0);
    chk("flags", 8'hc4, rd);
    wb(0, IDX_COUNT_HIGH, 0);
    chk("count high", 8'h12, rd);
    wb(0, IDX_COUNT_LOW, 0);
    span("count low", rl, rl + 14, rd);
    wb(0, IDX_IRQ_STATUS, 0);
    chk("status", 8'h03, rd);
    chk("irq", 0, irq);
    wb(0, IDX_CONTROL, 0);
    chk("flags kept", 8'hc4, rd);
    wb(1, IDX_CONTROL, 0);
    wb(0, IDX_COUNT_LOW, 0);
    lo = rd;
    repeat (20) @(posedge ref_clk);
    wb(0, IDX_COUNT_LOW, 0);
    chk("held count", lo, rd);
    wb(1, IDX_COUNT_LOW, 8'hfe);
    wb(1, IDX_IRQ_MASK, 8'h03);
    wb(1, IDX_CONTROL, 8'h28);
    waitirq();
    wb(0, IDX_CONTROL, 0);
    chk("split flags", 8'h68, rd);
    wb(0, IDX_COUNT_HIGH, 0);
    chk("split high", 8'h12, rd);
    wb(0, IDX_COUNT_LOW, 0);
    span("split low", rl, rl + 14, rd);
    wb(0, IDX_IRQ_STATUS, 0);
    chk("split status", 8'h02, rd);
    wb(1, IDX_CLOCK_CONTROL, 8'h02);
    wb(1, IDX_CONTROL, 8'h0c);
    waitirq();
    wb(0, IDX_CONTROL, 0);
    chk("high flag", 8'h8c, rd);
    wb(0, IDX_COUNT_HIGH, 0);
    span("high reload", 8'h12, 8'h1f, rd);
    // Ticks are counted over a window because bus cycles shift the phase.
    for (int k = 0; k < 2; k++) begin
      wb(1, IDX_CONTROL, 0);
      wb(1, IDX_CLOCK_CONTROL, 0);
      wb(1, IDX_COUNT_LOW, 0);
      wb(1, IDX_CONTROL, 8'(8'h04 | k));
      repeat (240 * (k + 1)) @(posedge ref_clk);
      wb(0, IDX_COUNT_LOW, 0);
      span("divided ticks", 19 - 10 * k, 21 - 10 * k, rd);
    end
    print_verdict();
  end
endmodule // tb_top
